// File: logic/rvf_pkg.sv
// Shared constants, types and helpers for the message identifier framer.
package rvf_pkg;

    // ==========================================================
    // Clock and bit timing
    localparam int CLK_HZ         = 100_000_000; // Reference clock rate
    localparam int BIT_RATE_KBPS  = 250;         // Link rate in kbit/s
    localparam int BIT_HZ         = BIT_RATE_KBPS * 1000;
    localparam int TQ_PER_BIT     = 40;          // Time quanta in one bit
    localparam int SAMPLE_TQ      = 35;          // Sample point, 87.5 %
    localparam int SAMPLE_MIN_PCT = 85;          // Earliest sample point
    localparam int SAMPLE_MAX_PCT = 90;          // Latest sample point

    // ==========================================================
    // Frame format
    localparam logic [3:0] DLC_FULL = 4'h8;      // Payload always eight bytes
    localparam int ID_W       = 29;              // Extended identifier width
    localparam int DGN_W      = 17;              // Data group number width
    localparam int ID_RSVD    = 25;              // Reserved identifier bit
    localparam int ID_DGN_HI  = 24;              // Top of the group number
    localparam int ID_DGN_LO  = 8;               // Bottom of the group number
    localparam int ID_SA_HI   = 7;               // Top of the source address

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TX_HDR  = 8'h04;
    localparam logic [7:0] OFS_TX_LO   = 8'h08;
    localparam logic [7:0] OFS_TX_HI   = 8'h0c;
    localparam logic [7:0] OFS_SA      = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_DISCARD = 8'h18;
    localparam logic [7:0] OFS_RX_ID   = 8'h1c;
    localparam logic [7:0] OFS_RX_DGN  = 8'h20;
    localparam logic [7:0] OFS_RX_SA   = 8'h24;
    localparam logic [7:0] OFS_RX_LO   = 8'h28;
    localparam logic [7:0] OFS_RX_HI   = 8'h2c;

    // Control and status bit positions
    localparam int CTRL_GO       = 0;            // Write one to send
    localparam int CTRL_SA_DYN   = 1;            // Use claimed address
    localparam int CTRL_TX_ALNUM = 2;            // Transmit payload as text
    localparam int CTRL_RX_ALNUM = 3;            // Present payload as text
    localparam int STAT_BUSY     = 0;            // Frame offered to controller
    localparam int STAT_RX_NEW   = 1;            // Accepted frame waiting

    // Reset value and counter width
    localparam logic [7:0] SA_DYN_RST = 8'hfe;   // Claimed address before claim
    localparam int         DISC_W     = 16;      // Discard counter width

    // ==========================================================
    // Transmit handshake states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_WAIT = 2'b10
    } rvf_tx_state_t;

    // Priority on top, reserved zero, group number, address at the bottom
    function automatic logic [ID_W-1:0] pack_id(input logic [2:0] prio,
                                                input logic [DGN_W-1:0] data_group_number,
                                                input logic [7:0] sa);
        pack_id = {prio, 1'b0, data_group_number, sa};
    endfunction

    // Reverse byte order of an eight-byte payload
    function automatic logic [63:0] swap_bytes(input logic [63:0] d);
        swap_bytes = '0;
        for (int i = 0; i < 8; i++) begin
            swap_bytes[8*i +: 8] = d[8*(7-i) +: 8];
        end
    endfunction

endpackage

// File: logic/rvf_bit_timer.sv
// Bit and sample point strobes for the link rate.
`timescale 1ns/1ns
module rvf_bit_timer #(
    parameter int CLK_HZ     = rvf_pkg::CLK_HZ,
    parameter int BIT_HZ     = rvf_pkg::BIT_HZ,
    parameter int TQ_PER_BIT = rvf_pkg::TQ_PER_BIT,
    parameter int SAMPLE_TQ  = rvf_pkg::SAMPLE_TQ
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // Strobes
    output logic      bit_tick_o,
    output logic      sample_tick_o
);
    localparam int CYC_PER_BIT = CLK_HZ / BIT_HZ;        // 400 at defaults
    localparam int PRESC       = CYC_PER_BIT / TQ_PER_BIT;
    localparam logic [15:0] LAST = 16'(CYC_PER_BIT - 1);
    localparam logic [15:0] SMP  = 16'(SAMPLE_TQ * PRESC - 1);

    // Refuse a bit that is not whole quanta or a sample point out of window
    if ((CYC_PER_BIT % TQ_PER_BIT) != 0 || CYC_PER_BIT > 65535 ||
        SAMPLE_TQ * 100 < rvf_pkg::SAMPLE_MIN_PCT * TQ_PER_BIT ||
        SAMPLE_TQ * 100 > rvf_pkg::SAMPLE_MAX_PCT * TQ_PER_BIT) begin : g_bad
        $error("rvf_bit_timer: bit timing parameters out of range");
    end

    typedef struct packed {
        logic [15:0] cnt;       // Cycle within the bit
        logic        bit_tick;  // Start of bit
        logic        smp_tick;  // Sample point
    } rvf_tmr_t;

    rvf_tmr_t st_reg;
    rvf_tmr_t st_next;

    // ==========================================================
    // Next state
    always_comb begin
        st_next          = st_reg;
        st_next.cnt      = (st_reg.cnt == LAST) ? 16'h0000 : st_reg.cnt + 16'h0001;
        st_next.bit_tick = (st_reg.cnt == LAST);
        st_next.smp_tick = (st_reg.cnt == SMP);
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bit_tick_o    = st_reg.bit_tick;
    assign sample_tick_o = st_reg.smp_tick;
endmodule

// File: logic/rvf_rx_filter.sv
// Receive frame format check; passes only extended eight-byte data frames.
`timescale 1ns/1ns
module rvf_rx_filter (
    // Clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     reset_i,
    // Frame from the controller
    input  wire logic                     valid_i,
    input  wire logic [rvf_pkg::ID_W-1:0] id_i,
    input  wire logic                     ide_i,
    input  wire logic                     rtr_i,
    input  wire logic [3:0]               dlc_i,
    input  wire logic [63:0]              data_i,
    // Verdict
    output logic                          accept_o,
    output logic                          discard_o,
    output logic [rvf_pkg::ID_W-1:0]      id_o,
    output logic [63:0]                   data_o
);
    typedef struct packed {
        logic                     acc;   // Good frame pulse
        logic                     disc;  // Dropped frame pulse
        logic [rvf_pkg::ID_W-1:0] id;    // Captured identifier
        logic [63:0]              data;  // Captured payload
    } rvf_flt_t;

    rvf_flt_t st_reg;
    rvf_flt_t st_next;
    logic     good;

    // ==========================================================
    // Judge and capture; a dropped frame leaves the last good one intact
    always_comb begin
        st_next      = st_reg;
        good         = ide_i && !rtr_i && (dlc_i == rvf_pkg::DLC_FULL);
        st_next.acc  = valid_i && good;
        st_next.disc = valid_i && !good;
        if (valid_i && good) begin
            st_next.id   = id_i;
            st_next.data = data_i;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign accept_o  = st_reg.acc;
    assign discard_o = st_reg.disc;
    assign id_o      = st_reg.id;
    assign data_o    = st_reg.data;
endmodule

// File: logic/rvf_framer.sv
// Message identifier framer and parser with an APB register file.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module rvf_framer (
    // Clock and reset
    input  wire logic                     REF_CLK_I,
    input  wire logic                     RESET_I,
    // APB slave
    input  wire logic                     PSEL_I,
    input  wire logic                     PENABLE_I,
    input  wire logic                     PWRITE_I,
    input  wire logic [7:0]               PADDR_I,
    input  wire logic [31:0]              PWDATA_I,
    output logic [31:0]                   PRDATA_O,
    output logic                          PREADY_O,
    output logic                          PSLVERR_O,
    // Fixed node address strap
    input  wire logic [7:0]               SA_STRAP_I,
    // Transmit frame to the controller
    output logic                          TX_VALID_O,
    input  wire logic                     TX_READY_I,
    output logic [rvf_pkg::ID_W-1:0]      TX_ID_O,
    output logic                          TX_IDE_O,
    output logic                          TX_RTR_O,
    output logic [3:0]                    TX_DLC_O,
    output logic [63:0]                   TX_DATA_O,
    // Receive frame from the controller
    input  wire logic                     RX_VALID_I,
    input  wire logic [rvf_pkg::ID_W-1:0] RX_ID_I,
    input  wire logic                     RX_IDE_I,
    input  wire logic                     RX_RTR_I,
    input  wire logic [3:0]               RX_DLC_I,
    input  wire logic [63:0]              RX_DATA_I,
    // Bit timing strobes for the controller
    output logic                          BIT_TICK_O,
    output logic                          SAMPLE_TICK_O
);

    // ==========================================================
    // Register state
    typedef struct packed {
        logic                         sa_dyn_sel;  // Claimed address in use
        logic                         tx_alnum;    // Send payload as text
        logic                         rx_alnum;    // Show payload as text
        logic [2:0]                   tx_prio;     // Next frame priority
        logic [rvf_pkg::DGN_W-1:0]    tx_dgn;      // Next frame group number
        logic [63:0]                  tx_buf;      // Next frame payload value
        logic [7:0]                   sa_claim;    // Address from claiming
        logic [7:0]                   sa_fixed;    // Address from the strap
        logic                         strap_done;  // Strap caught once
        rvf_pkg::rvf_tx_state_t       tx_state;    // Handshake state
        logic [rvf_pkg::ID_W-1:0]     tx_id;       // Offered identifier
        logic [63:0]                  tx_data;     // Offered payload bytes
        logic                         rx_new;      // Accepted frame pending
        logic [rvf_pkg::ID_W-1:0]     rx_id;       // Last accepted identifier
        logic [63:0]                  rx_data;     // Last accepted payload
        logic [rvf_pkg::DISC_W-1:0]   disc_cnt;    // Dropped frame count
        logic [31:0]                  prdata;      // Read data for access
        logic                         pslverr;     // Error for access
    } rvf_regs_t;

    rvf_regs_t st_reg;
    rvf_regs_t st_next;

    // Filter outputs
    logic                     flt_acc;
    logic                     flt_disc;
    logic [rvf_pkg::ID_W-1:0] flt_id;
    logic [63:0]              flt_data;

    // Bus decode helpers
    logic        setup_rd;     // Setup cycle of a read
    logic        acc_wr;       // Write completing this edge
    logic        mapped;       // Address hits a register
    logic [7:0]  eff_sa;       // Address that goes into frames
    logic [31:0] rd_word;      // Word selected for read
    logic [63:0] rx_view;      // Received payload in chosen order

    // ==========================================================
    // Bit timing strobes
    rvf_bit_timer u_timer (
        .ref_clk_i     (REF_CLK_I),
        .reset_i       (RESET_I),
        .bit_tick_o    (BIT_TICK_O),
        .sample_tick_o (SAMPLE_TICK_O)
    );

    // ==========================================================
    // Receive format check
    rvf_rx_filter u_filter (
        .ref_clk_i (REF_CLK_I),
        .reset_i   (RESET_I),
        .valid_i   (RX_VALID_I),
        .id_i      (RX_ID_I),
        .ide_i     (RX_IDE_I),
        .rtr_i     (RX_RTR_I),
        .dlc_i     (RX_DLC_I),
        .data_i    (RX_DATA_I),
        .accept_o  (flt_acc),
        .discard_o (flt_disc),
        .id_o      (flt_id),
        .data_o    (flt_data)
    );

    // ==========================================================
    // Address decode; only aligned words of the map answer
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            rvf_pkg::OFS_CTRL,
            rvf_pkg::OFS_TX_HDR,
            rvf_pkg::OFS_TX_LO,
            rvf_pkg::OFS_TX_HI,
            rvf_pkg::OFS_SA,
            rvf_pkg::OFS_STATUS,
            rvf_pkg::OFS_DISCARD,
            rvf_pkg::OFS_RX_ID,
            rvf_pkg::OFS_RX_DGN,
            rvf_pkg::OFS_RX_SA,
            rvf_pkg::OFS_RX_LO,
            rvf_pkg::OFS_RX_HI: is_mapped = 1'b1;
            default:            is_mapped = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Combinational helpers
    always_comb begin
        setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
        acc_wr   = PSEL_I && PENABLE_I && PWRITE_I;
        mapped   = is_mapped(PADDR_I);
        // Strapped address unless software selected the claimed one
        eff_sa   = st_reg.sa_dyn_sel ? st_reg.sa_claim : st_reg.sa_fixed;
        // Text arrives first byte first, so show it reversed
        rx_view  = st_reg.rx_alnum ? rvf_pkg::swap_bytes(st_reg.rx_data) : st_reg.rx_data;
    end

    // Read word for the current address
    always_comb begin
        rd_word = 32'h0000_0000;
        case (PADDR_I)
            rvf_pkg::OFS_CTRL: begin
                rd_word[rvf_pkg::CTRL_SA_DYN]   = st_reg.sa_dyn_sel;
                rd_word[rvf_pkg::CTRL_TX_ALNUM] = st_reg.tx_alnum;
                rd_word[rvf_pkg::CTRL_RX_ALNUM] = st_reg.rx_alnum;
            end
            rvf_pkg::OFS_TX_HDR: begin
                // Reads back in identifier layout, reserved bit as zero
                rd_word[rvf_pkg::ID_W-1:0] = rvf_pkg::pack_id(st_reg.tx_prio, st_reg.tx_dgn, eff_sa);
            end
            rvf_pkg::OFS_TX_LO: begin
                rd_word = st_reg.tx_buf[31:0];
            end
            rvf_pkg::OFS_TX_HI: begin
                rd_word = st_reg.tx_buf[63:32];
            end
            rvf_pkg::OFS_SA: begin
                rd_word[7:0]   = st_reg.sa_claim;
                rd_word[15:8]  = eff_sa;
                rd_word[23:16] = st_reg.sa_fixed;
            end
            rvf_pkg::OFS_STATUS: begin
                rd_word[rvf_pkg::STAT_BUSY]   = (st_reg.tx_state == rvf_pkg::TX_WAIT);
                rd_word[rvf_pkg::STAT_RX_NEW] = st_reg.rx_new;
            end
            rvf_pkg::OFS_DISCARD: begin
                rd_word[rvf_pkg::DISC_W-1:0] = st_reg.disc_cnt;
            end
            rvf_pkg::OFS_RX_ID: begin
                rd_word[rvf_pkg::ID_W-1:0] = st_reg.rx_id;
            end
            rvf_pkg::OFS_RX_DGN: begin
                // Upper and lower parts joined into one number
                rd_word[rvf_pkg::DGN_W-1:0] = st_reg.rx_id[rvf_pkg::ID_DGN_HI:rvf_pkg::ID_DGN_LO];
            end
            rvf_pkg::OFS_RX_SA: begin
                // Sender address kept apart; payload paths never use it
                rd_word[7:0] = st_reg.rx_id[rvf_pkg::ID_SA_HI:0];
            end
            rvf_pkg::OFS_RX_LO: begin
                rd_word = rx_view[31:0];
            end
            rvf_pkg::OFS_RX_HI: begin
                rd_word = rx_view[63:32];
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ==========================================================
    // Next state of the whole block
    always_comb begin
        st_next = st_reg;

        // Catch the strap once after reset release, never during reset
        if (!st_reg.strap_done) begin
            st_next.sa_fixed   = SA_STRAP_I;
            st_next.strap_done = 1'b1;
        end

        // Read data is latched in the setup cycle for a zero-wait access
        if (setup_rd) begin
            st_next.prdata = mapped ? rd_word : 32'h0000_0000;
        end
        if (PSEL_I && !PENABLE_I) begin
            st_next.pslverr = !mapped;
        end

        // Register writes take effect at the access edge
        if (acc_wr && mapped) begin
            case (PADDR_I)
                rvf_pkg::OFS_CTRL: begin
                    st_next.sa_dyn_sel = PWDATA_I[rvf_pkg::CTRL_SA_DYN];
                    st_next.tx_alnum   = PWDATA_I[rvf_pkg::CTRL_TX_ALNUM];
                    st_next.rx_alnum   = PWDATA_I[rvf_pkg::CTRL_RX_ALNUM];
                end
                rvf_pkg::OFS_TX_HDR: begin
                    // Address bits and bit 25 are not writable here
                    st_next.tx_prio = PWDATA_I[28:26];
                    st_next.tx_dgn  = PWDATA_I[rvf_pkg::ID_DGN_HI:rvf_pkg::ID_DGN_LO];
                end
                rvf_pkg::OFS_TX_LO: begin
                    st_next.tx_buf[31:0] = PWDATA_I;
                end
                rvf_pkg::OFS_TX_HI: begin
                    st_next.tx_buf[63:32] = PWDATA_I;
                end
                rvf_pkg::OFS_SA: begin
                    st_next.sa_claim = PWDATA_I[7:0];
                end
                default: begin
                    st_next.sa_claim = st_next.sa_claim;
                end
            endcase
        end

        // Transmit handshake; frame fields freeze while offered
        case (st_reg.tx_state)
            rvf_pkg::TX_IDLE: begin
                if (acc_wr && PADDR_I == rvf_pkg::OFS_CTRL && PWDATA_I[rvf_pkg::CTRL_GO]) begin
                    // Priority leads, own address trails for arbitration
                    st_next.tx_id    = rvf_pkg::pack_id(st_reg.tx_prio, st_reg.tx_dgn, eff_sa);
                    // Numbers go low byte first; text goes high byte first
                    st_next.tx_data  = st_reg.tx_alnum ? rvf_pkg::swap_bytes(st_reg.tx_buf)
                                                       : st_reg.tx_buf;
                    st_next.tx_state = rvf_pkg::TX_WAIT;
                end
            end
            rvf_pkg::TX_WAIT: begin
                // A go written while busy is ignored
                if (TX_READY_I) begin
                    st_next.tx_state = rvf_pkg::TX_IDLE;
                end
            end
            default: begin
                st_next.tx_state = rvf_pkg::TX_IDLE;
            end
        endcase

        // Pending flag: write one clears, a new frame in the same cycle wins
        if (acc_wr && PADDR_I == rvf_pkg::OFS_STATUS && PWDATA_I[rvf_pkg::STAT_RX_NEW]) begin
            st_next.rx_new = 1'b0;
        end
        if (flt_acc) begin
            // Newest frame overwrites an unread one
            st_next.rx_new  = 1'b1;
            st_next.rx_id   = flt_id;
            st_next.rx_data = flt_data;
        end

        // Dropped frames counted, saturating at all ones so software sees a ceiling
        if (flt_disc && st_reg.disc_cnt != '1) begin
            st_next.disc_cnt = st_reg.disc_cnt + rvf_pkg::DISC_W'(1);
        end
    end

    // ==========================================================
    // State register with synchronous reset
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            st_reg          <= '0;
            st_reg.tx_state <= rvf_pkg::TX_IDLE;
            st_reg.sa_claim <= rvf_pkg::SA_DYN_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    assign PRDATA_O   = st_reg.prdata;
    assign PREADY_O   = 1'b1;                           // Zero wait states
    assign PSLVERR_O  = PSEL_I && PENABLE_I && st_reg.pslverr;
    assign TX_VALID_O = (st_reg.tx_state == rvf_pkg::TX_WAIT);
    assign TX_ID_O    = st_reg.tx_id;
    assign TX_IDE_O   = 1'b1;
    assign TX_RTR_O   = 1'b0;
    assign TX_DLC_O   = rvf_pkg::DLC_FULL;
    assign TX_DATA_O  = st_reg.tx_data;

endmodule

// File: sim/rvf_framer_sva.sv
// Concurrent checks on the framer's ports.
`timescale 1ns/1ns
module rvf_framer_sva (
    // Clock, reset and APB
    input wire logic                     REF_CLK_I,
    input wire logic                     RESET_I,
    input wire logic                     PSEL_I,
    input wire logic                     PENABLE_I,
    input wire logic                     PREADY_O,
    input wire logic                     PSLVERR_O,
    // Transmit side and strobes
    input wire logic                     TX_VALID_O,
    input wire logic                     TX_READY_I,
    input wire logic [rvf_pkg::ID_W-1:0] TX_ID_O,
    input wire logic                     TX_IDE_O,
    input wire logic                     TX_RTR_O,
    input wire logic [3:0]               TX_DLC_O,
    input wire logic [63:0]              TX_DATA_O,
    input wire logic                     BIT_TICK_O,
    input wire logic                     SAMPLE_TICK_O
);
    // ==========================================
    // One domain, so one clock and one disable
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    a_ext_eight_dlc: assert property (TX_VALID_O |-> TX_IDE_O && TX_DLC_O == 4'h8) else $error("bad format");
    a_never_remote: assert property (TX_VALID_O |-> !TX_RTR_O) else $error("remote frame offered");
    a_rsvd_bit_zero: assert property (TX_VALID_O |-> !TX_ID_O[25]) else $error("reserved bit set");
    // A stalled offer must not change under the controller
    a_offer_holds: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_ID_O)
        && $stable(TX_DATA_O)) else $error("offer changed while stalled");
    a_offer_ends: assert property (TX_VALID_O && TX_READY_I |=> !TX_VALID_O) else $error("offer stayed");
    a_sample_point: assert property (BIT_TICK_O |-> ##[350:350] SAMPLE_TICK_O) else $error("sample late");
    a_bit_period: assert property (SAMPLE_TICK_O |-> ##[50:50] BIT_TICK_O) else $error("bit period wrong");
    a_err_in_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("error outside access");
    a_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O) else $error("ready low in access");
    c_offer: cover property (TX_VALID_O && TX_READY_I);
    c_stall: cover property (TX_VALID_O && !TX_READY_I);
    c_error: cover property (PSLVERR_O);
endmodule
bind rvf_framer rvf_framer_sva chk (.*);

// File: sim/rvf_can_ctrl_model.sv
// Controller stand-in: accepts offered frames after a set stall.
`timescale 1ns/1ns
module rvf_can_ctrl_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Offer handshake
    input  wire logic       valid_i,
    input  wire logic [7:0] stall_i,
    output logic            ready_o
);
    logic [7:0] cnt_reg; // Cycles the current offer has waited
    // Ready pulses once per offer, after stall_i + 1 waiting cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !valid_i || ready_o) begin
            cnt_reg <= 8'h00;
            ready_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            ready_o <= (cnt_reg == stall_i);
        end
    end
endmodule

// File: sim/test_rvf_framer.sv
// Self-checking bench for the identifier framer.
`timescale 1ns/1ns
module test_rvf_framer;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, prdy, perr, txv, txr, ide = 1, rtr = 0, rxv = 0;
    logic [7:0] pa = 8'h00, stall = 8'h00;
    logic [31:0] pwd = 32'h0, prd, r;
    logic [28:0] txid, rxid = 29'h0;
    logic [3:0] dlc = 4'h8;
    logic [63:0] txd, rxd = 64'h0;
    int err_count = 0, n_checks = 0;
    always #5 clk = ~clk;
    rvf_framer uut (.REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw),
        .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .SA_STRAP_I(8'h5a), .TX_VALID_O(txv), .TX_READY_I(txr), .TX_ID_O(txid), .TX_IDE_O(),
        .TX_RTR_O(), .TX_DLC_O(), .TX_DATA_O(txd), .RX_VALID_I(rxv), .RX_ID_I(rxid), .RX_IDE_I(ide),
        .RX_RTR_I(rtr), .RX_DLC_I(dlc), .RX_DATA_I(rxd), .BIT_TICK_O(), .SAMPLE_TICK_O());
    rvf_can_ctrl_model ctl (.clk_i(clk), .rst_i(rst), .valid_i(txv), .stall_i(stall), .ready_o(txr));
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // APB master: setup, then access held until ready is sampled high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] rd, output logic e);
        int n;
        @(posedge clk) {psel, pen, pw, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk) pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 50);
        if (n >= 50) begin err_count++; tally_and_finish(); end
        rd = prd;
        e = perr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] ex);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, ex, r);
    endtask
    // Send one frame, with the controller stalling s + 1 cycles
    task automatic send(logic [31:0] hdr, logic [31:0] ctrl, logic [7:0] s, logic [28:0] eid, logic [63:0] ed);
        int n;
        logic e;
        stall <= s;
        apb(1'b1, rvf_pkg::OFS_TX_HDR, hdr, r, e);
        // Mode bits settle first: a go takes the options already held, not the ones written with it
        apb(1'b1, rvf_pkg::OFS_CTRL, ctrl & ~32'h1, r, e);
        apb(1'b1, rvf_pkg::OFS_CTRL, ctrl, r, e);
        n = 0;
        do begin @(posedge clk); n++; end while (!(txv === 1'b1 && txr === 1'b1) && n < 100);
        if (n >= 100) begin err_count++; tally_and_finish(); end
        chk("tx id", {35'h0, eid}, {35'h0, txid});
        chk("tx data", ed, txd);
    endtask
    task automatic rx_frame(logic i, logic t, logic [3:0] l, logic [28:0] id);
        @(posedge clk) {rxv, ide, rtr, dlc, rxid, rxd} <= {1'b1, i, t, l, id, 64'h0807060504030201};
    endtask
    initial begin
        logic e;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk("address", rvf_pkg::OFS_SA, 32'h005a5afe);
        apb(1'b1, rvf_pkg::OFS_TX_LO, 32'h04030201, r, e);
        apb(1'b1, rvf_pkg::OFS_TX_HI, 32'h08070605, r, e);
        // Reserved bit written as one must still go out as zero
        send({3'b111, 1'b1, 17'h1ea12, 8'h00}, 32'h1, 8'd0, {3'b111, 1'b0, 17'h1ea12, 8'h5a}, 64'h0807060504030201);
        apb(1'b1, rvf_pkg::OFS_SA, 32'h42, r, e);
        send({6'h00, 17'h0ee00, 8'h00}, 32'h7, 8'd5, {3'b000, 1'b0, 17'h0ee00, 8'h42}, 64'h0102030405060708);
        rx_frame(1'b1, 1'b0, 4'h8, {3'd6, 1'b0, 17'h1fe44, 8'h33});
        rx_frame(1'b0, 1'b0, 4'h8, 29'h0);
        rx_frame(1'b1, 1'b1, 4'h8, 29'h0);
        rx_frame(1'b1, 1'b0, 4'h7, 29'h0);
        @(posedge clk) rxv <= 1'b0;
        rd_chk("rx group", rvf_pkg::OFS_RX_DGN, 32'h1fe44);
        rd_chk("rx address", rvf_pkg::OFS_RX_SA, 32'h33);
        rd_chk("rx low", rvf_pkg::OFS_RX_LO, 32'h04030201);
        rd_chk("dropped", rvf_pkg::OFS_DISCARD, 32'h3);
        rd_chk("rx pending", rvf_pkg::OFS_STATUS, 32'h2);
        apb(1'b1, rvf_pkg::OFS_STATUS, 32'h2, r, e);
        rd_chk("rx cleared", rvf_pkg::OFS_STATUS, 32'h0);
        apb(1'b0, 8'h30, 32'h0, r, e);
        chk("unmapped error", 64'h1, {63'h0, e});
        repeat (900) @(posedge clk);
        tally_and_finish();
    end
endmodule
